// [rtl/sic_pkg.sv]
// ****************************************************************
// Shared constants and types for the input configuration block
// ****************************************************************
package sic_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] SIC_TEST_CTRL_OFF   = 8'h03;
   localparam logic [7:0] SIC_IN1_FREQ_OFF    = 8'h22;
   localparam logic [7:0] SIC_IN2_FREQ_OFF    = 8'h23;
   localparam logic [7:0] SIC_MODE_CFG_OFF    = 8'h34;
   localparam logic [7:0] SIC_OUT_STD_OFF     = 8'h38;
   localparam logic [7:0] SIC_IN1_TOL_OFF     = 8'h41;
   localparam logic [7:0] SIC_IN2_TOL_OFF     = 8'h42;
   localparam logic [7:0] SIC_DIVN_LO_OFF     = 8'h46;
   localparam logic [7:0] SIC_DIVN_HI_OFF     = 8'h47;
   localparam logic [7:0] SIC_SYNTH_STD_OFF   = 8'h64;
   localparam logic [7:0] SIC_STATUS_OFF      = 8'h7e;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int SIC_EDGE_SEL_BIT   = 2;  // test_control_one
   localparam int SIC_NET_STD_BIT    = 2;  // input_mode_config
   localparam int SIC_OUT_STD_BIT_A  = 5;  // output standard register
   localparam int SIC_OUT_STD_BIT_B  = 6;
   localparam int SIC_SYNTH_STD_BIT  = 4;
   localparam int SIC_DIVN_HI_W      = 6;  // N is 14 bits wide

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] SIC_TEST_CTRL_RST  = 8'h00;
   localparam logic [7:0] SIC_FREQ_RST       = 8'h00;
   localparam logic [7:0] SIC_MODE_CFG_RST   = 8'h00;
   localparam logic [7:0] SIC_OUT_STD_RST    = 8'h00;
   localparam logic [7:0] SIC_SYNTH_STD_RST  = 8'h00;
   localparam logic [7:0] SIC_TOL_RST        = 8'h50;  // 80 ppm
   localparam logic [7:0] SIC_DIVN_LO_RST    = 8'h00;
   localparam logic [7:0] SIC_DIVN_HI_RST    = 8'h00;

   // ****************************************************************
   // Expected frequency codes
   // ****************************************************************
   localparam logic [3:0] SIC_F_8K      = 4'h0;
   localparam logic [3:0] SIC_F_1544K   = 4'h1;
   localparam logic [3:0] SIC_F_2048K   = 4'h2;
   localparam logic [3:0] SIC_F_6480K   = 4'h3;
   localparam logic [3:0] SIC_F_19440K  = 4'h4;
   localparam logic [3:0] SIC_F_25920K  = 4'h5;
   localparam logic [3:0] SIC_F_38880K  = 4'h6;
   localparam logic [3:0] SIC_F_51840K  = 4'h7;
   localparam logic [3:0] SIC_F_77760K  = 4'h8;
   localparam int         SIC_F_CODES   = 9;

   // Division ratio down to 8 kHz, indexed by frequency code
   localparam logic [13:0] SIC_TO_8K_RATIO [SIC_F_CODES] = '{
      14'd1, 14'd193, 14'd256, 14'd810, 14'd2430,
      14'd3240, 14'd4860, 14'd6480, 14'd9720};

   // Input period in clock cycles at 125 MHz, indexed by code
   localparam logic [15:0] SIC_PERIOD_CYC [SIC_F_CODES] = '{
      16'd15625, 16'd81, 16'd61, 16'd19, 16'd6,
      16'd5, 16'd3, 16'd2, 16'd2};

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int SIC_CLK_KHZ         = 125000;
   localparam int SIC_RESET_REL_MS    = 250;
   localparam int SIC_APLL_SETTLE_MS  = 1;
   localparam int SIC_INIT_CYCLES     =
      (SIC_RESET_REL_MS + SIC_APLL_SETTLE_MS) * SIC_CLK_KHZ;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sic_reg_req_t;

   typedef struct packed {
      logic       divn;      // bit 7
      logic       lock_to_8k_mode; // bit 6
      logic [1:0] bucket_id; // bits 5:4
      logic [3:0] code;      // bits 3:0
   } sic_freq_cfg_t;

   typedef struct packed {
      logic [2:0] freq_sel;
      logic       net_std;
   } sic_strap_t;

   typedef enum logic [1:0] {
      SIC_LOAD = 2'b00,
      SIC_WAIT = 2'b01,
      SIC_RUN  = 2'b11
   } sic_phase_t;

endpackage : sic_pkg

// [rtl/sic_prediv.sv]
`timescale 1ns/1ps
// ****************************************************************
// Edge counting pre-divider ahead of the phase comparator
// ****************************************************************
module sic_prediv #(
   parameter int CNT_W = 14
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             enable,
   input  wire logic [CNT_W-1:0] ratio,
   // Edge in, divided edge out
   input  wire logic             edge_in,
   output logic                  div_pulse
);
   import sic_pkg::*;

   logic [CNT_W-1:0] count;

   // Count qualifying edges, pulse on the last one of each group
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count     <= '0;
         div_pulse <= 1'b0;
      end else if (!enable) begin
         count     <= '0;  // Held clear in direct mode, so counting restarts cleanly
         div_pulse <= 1'b0;
      end else if (edge_in) begin
         if (count + CNT_W'(1) >= ratio) begin
            count     <= '0;
            div_pulse <= 1'b1;
         end else begin
            count     <= count + CNT_W'(1);
            div_pulse <= 1'b0;
         end
      end else begin
         div_pulse <= 1'b0;
      end
   end

endmodule : sic_prediv

// [rtl/sic_input_select.sv]
`timescale 1ns/1ps
// Overview of operation
// - Frequency-select and standard straps sampled only during reset as 4-bit code.
// - Code 000 8k; 001 2.048/1.544 by standard; 010-111 6.48 to 77.76 MHz.
// - Every reset loads the same strap frequency into both inputs.
// - Later resets overwrite frequency registers from the straps present then.
// - Strap changes after reset and initialization are ignored.
// - Standard bit one means SONET, zero SDH, device-wide.
// - Direct mode compares phase at the input's own frequency.
// - Lock-to-8k bit 6 makes pre-divider reach 8 kHz for spot frequencies.
// - Bit 2 of test register 03 picks the input edge used by pre-divider.
// - Divide-by-N bit 7 divides input by N+1, N from 1 to 12499.
// - One shared N; both inputs in divide-by-N need equal source frequency.
// - Shared N held in register pair 46 and 47.
// - Frequency value 10XX0000 enables divide-by-N with 8 kHz code, XX bucket id.
// - Initialization window is 250 ms reset release plus 1 ms APLL start.
// - After initialization select pin high picks input 1, low input 2.
// - Tolerance registers 41 and 42 default to 80 ppm, writable later.
// - After initialization acts as plain selector, DPLL tracking chosen input.
// - Standard strap seeds reg 34 bit 2, reg 38 bits 5,6, reg 64 bit 4.
// - About two missing cycles raise loss-of-signal pin and freeze DPLL.
module sic_input_select #(
   parameter int INIT_CYCLES = sic_pkg::SIC_INIT_CYCLES
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rstn,
   // Strap pins
   input  wire sic_pkg::sic_strap_t expected_freq_strap,
   // Reference inputs and select pin
   input  wire logic                reference_input_1,
   input  wire logic                reference_input_2,
   input  wire logic                source_select_pin,
   // Register port
   input  wire sic_pkg::sic_reg_req_t reg_req,
   output logic [7:0]               reg_rdata,
   // To digital_pll_one
   output logic                     phase_cmp_pulse,
   output logic                     dpll_holdover,
   output logic                     selected_is_input2,
   // Device status
   output logic                     loss_of_signal_pin,
   output logic                     network_standard_bit,
   output logic                     init_done
);
   import sic_pkg::*;

   localparam int ICW = $clog2(INIT_CYCLES + 1);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Strap code to expected frequency code
   function automatic logic [3:0] strap_decode(input sic_strap_t s);
      logic [3:0] c;
      c = SIC_F_8K;
      case (s.freq_sel)
         3'h0: c = SIC_F_8K;
         3'h1: c = s.net_std ? SIC_F_1544K : SIC_F_2048K;
         3'h2: c = SIC_F_6480K;
         3'h3: c = SIC_F_19440K;
         3'h4: c = SIC_F_25920K;
         3'h5: c = SIC_F_38880K;
         3'h6: c = SIC_F_51840K;
         default: c = SIC_F_77760K;
      endcase
      return c;
   endfunction : strap_decode

   // Clamp an out-of-table code onto the 8 kHz entry
   function automatic int code_index(input logic [3:0] c);
      int i;
      i = (int'(c) < SIC_F_CODES) ? int'(c) : 0;
      return i;
   endfunction : code_index

   // Loss limit: two and a half nominal periods
   function automatic logic [15:0] los_limit(input logic [3:0] c);
      logic [15:0] p;
      p = SIC_PERIOD_CYC[code_index(c)];
      return (p << 1) + (p >> 1) + 16'h0001;
   endfunction : los_limit

   // ****************************************************************
   // Register state
   // ****************************************************************
   sic_phase_t    phase;
   sic_strap_t    strap_q;
   logic [ICW-1:0] init_cnt;
   logic [7:0]    test_ctrl;
   sic_freq_cfg_t in1_cfg;
   sic_freq_cfg_t in2_cfg;
   logic [7:0]    mode_cfg;
   logic [7:0]    out_std;
   logic [7:0]    synth_std;
   logic [7:0]    in1_tol;
   logic [7:0]    in2_tol;
   logic [7:0]    divn_lo;
   logic [7:0]    divn_hi;
   logic          wr_ok;
   logic [3:0]    strap_code;

   assign wr_ok      = reg_req.wr && (phase != SIC_LOAD);
   assign strap_code = strap_decode(strap_q);

   // Straps follow the pins only while reset is held; no async reset
   // here so the flop never takes a port value asynchronously.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         strap_q <= expected_freq_strap;
      end
   end

   // ****************************************************************
   // Initialization sequence
   // ****************************************************************

   // Load straps, then hold the select pin off for the init window
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase    <= SIC_LOAD;
         init_cnt <= '0;
      end else begin
         case (phase)
            SIC_LOAD: begin
               phase    <= SIC_WAIT;
               init_cnt <= '0;
            end
            SIC_WAIT: begin
               if (init_cnt >= ICW'(INIT_CYCLES - 1)) begin
                  phase <= SIC_RUN;
               end else begin
                  init_cnt <= init_cnt + ICW'(1);
               end
            end
            default: phase <= SIC_RUN;
         endcase
      end
   end

   // ****************************************************************
   // Configuration registers
   // ****************************************************************

   // Per-input expected frequency; strap load wins over any write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in1_cfg <= SIC_FREQ_RST;
         in2_cfg <= SIC_FREQ_RST;
      end else if (phase == SIC_LOAD) begin
         in1_cfg <= {4'h0, strap_code};
         in2_cfg <= {4'h0, strap_code};
      end else if (wr_ok) begin
         if (reg_req.addr == SIC_IN1_FREQ_OFF) begin
            in1_cfg <= reg_req.wdata;
         end else if (reg_req.addr == SIC_IN2_FREQ_OFF) begin
            in2_cfg <= reg_req.wdata;
         end
      end
   end

   // Standard selection bits, all seeded from the standard strap
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_cfg  <= SIC_MODE_CFG_RST;
         out_std   <= SIC_OUT_STD_RST;
         synth_std <= SIC_SYNTH_STD_RST;
      end else if (phase == SIC_LOAD) begin
         mode_cfg[SIC_NET_STD_BIT]     <= strap_q.net_std;
         out_std[SIC_OUT_STD_BIT_A]    <= strap_q.net_std;
         out_std[SIC_OUT_STD_BIT_B]    <= strap_q.net_std;
         synth_std[SIC_SYNTH_STD_BIT]  <= strap_q.net_std;
      end else if (wr_ok) begin
         if (reg_req.addr == SIC_MODE_CFG_OFF) begin
            mode_cfg <= reg_req.wdata;
         end else if (reg_req.addr == SIC_OUT_STD_OFF) begin
            out_std <= reg_req.wdata;
         end else if (reg_req.addr == SIC_SYNTH_STD_OFF) begin
            synth_std <= reg_req.wdata;
         end
      end
   end

   // Test control, tolerances and shared divider value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         test_ctrl <= SIC_TEST_CTRL_RST;
         in1_tol   <= SIC_TOL_RST;
         in2_tol   <= SIC_TOL_RST;
         divn_lo   <= SIC_DIVN_LO_RST;
         divn_hi   <= SIC_DIVN_HI_RST;
      end else if (wr_ok) begin
         if (reg_req.addr == SIC_TEST_CTRL_OFF) begin
            test_ctrl <= reg_req.wdata;
         end else if (reg_req.addr == SIC_IN1_TOL_OFF) begin
            in1_tol <= reg_req.wdata;
         end else if (reg_req.addr == SIC_IN2_TOL_OFF) begin
            in2_tol <= reg_req.wdata;
         end else if (reg_req.addr == SIC_DIVN_LO_OFF) begin
            divn_lo <= reg_req.wdata;
         end else if (reg_req.addr == SIC_DIVN_HI_OFF) begin
            divn_hi <= {2'b00, reg_req.wdata[SIC_DIVN_HI_W-1:0]};
         end
      end
   end

   // ****************************************************************
   // Source selection and pre-division
   // ****************************************************************
   logic          sel_in2;
   sic_freq_cfg_t sel_cfg;
   logic          raw_now;
   logic          raw_prev;
   logic          rise;
   logic          fall;
   logic          div_active;
   logic [13:0]   div_ratio;
   logic [13:0]   shared_n;
   logic          div_pulse;

   // Select pin is ignored until init ends; input 1 is used meanwhile
   assign sel_in2  = (phase == SIC_RUN) && !source_select_pin;
   assign sel_cfg  = sel_in2 ? in2_cfg : in1_cfg;
   assign raw_now  = sel_in2 ? reference_input_2 : reference_input_1;
   assign rise     = raw_now && !raw_prev;
   assign fall     = !raw_now && raw_prev;
   // One N serves both inputs; the sources must then match in rate
   assign shared_n = {divn_hi[SIC_DIVN_HI_W-1:0], divn_lo};
   assign div_active = sel_cfg.divn || sel_cfg.lock_to_8k_mode;

   // Divide-by-N takes priority over the automatic 8 kHz ratio
   always_comb begin
      if (sel_cfg.divn) begin
         div_ratio = shared_n + 14'h0001;
      end else begin
         div_ratio = SIC_TO_8K_RATIO[code_index(sel_cfg.code)];
      end
   end

   // Previous level of the selected input for edge detection
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         raw_prev <= 1'b0;
      end else begin
         raw_prev <= raw_now;
      end
   end

   sic_prediv #(
      .CNT_W (14)
   ) u_prediv (
      .clk       (clk),
      .rstn      (rstn),
      .enable    (div_active),
      .ratio     (div_ratio),
      .edge_in   (test_ctrl[SIC_EDGE_SEL_BIT] ? fall : rise),
      .div_pulse (div_pulse)
   );

   // Comparator event: divided path or raw rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         phase_cmp_pulse <= 1'b0;
      end else if (phase == SIC_LOAD) begin
         phase_cmp_pulse <= 1'b0;
      end else begin
         phase_cmp_pulse <= div_active ? div_pulse : rise;
      end
   end

   // ****************************************************************
   // Fast activity monitor
   // ****************************************************************
   logic [15:0] gap_cnt;
   logic [15:0] gap_limit;

   // Both divided modes time the gap at the 8 kHz period, whatever rate N gives
   assign gap_limit = los_limit(div_active ? SIC_F_8K : sel_cfg.code);

   // Gap counter restarts on every comparator event and saturates
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gap_cnt <= '0;
      end else if (phase_cmp_pulse) begin
         gap_cnt <= '0;
      end else if (gap_cnt != 16'hffff) begin
         gap_cnt <= gap_cnt + 16'h0001;
      end
   end

   // Alarm and holdover together; they clear on the next event
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         loss_of_signal_pin <= 1'b0;
         dpll_holdover      <= 1'b0;
      end else if (phase_cmp_pulse) begin
         loss_of_signal_pin <= 1'b0;
         dpll_holdover      <= 1'b0;
      end else if (gap_cnt >= gap_limit) begin
         loss_of_signal_pin <= 1'b1;
         dpll_holdover      <= 1'b1;
      end
   end

   // ****************************************************************
   // Status outputs and read port
   // ****************************************************************

   // Registered copies of block state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         selected_is_input2   <= 1'b0;
         network_standard_bit <= 1'b0;
         init_done            <= 1'b0;
      end else begin
         selected_is_input2   <= sel_in2;
         network_standard_bit <= mode_cfg[SIC_NET_STD_BIT];
         init_done            <= (phase == SIC_RUN);
      end
   end

   // Read data latched on a read strobe; unmapped reads give zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         if (reg_req.addr == SIC_TEST_CTRL_OFF) begin
            reg_rdata <= test_ctrl;
         end else if (reg_req.addr == SIC_IN1_FREQ_OFF) begin
            reg_rdata <= in1_cfg;
         end else if (reg_req.addr == SIC_IN2_FREQ_OFF) begin
            reg_rdata <= in2_cfg;
         end else if (reg_req.addr == SIC_MODE_CFG_OFF) begin
            reg_rdata <= mode_cfg;
         end else if (reg_req.addr == SIC_OUT_STD_OFF) begin
            reg_rdata <= out_std;
         end else if (reg_req.addr == SIC_IN1_TOL_OFF) begin
            reg_rdata <= in1_tol;
         end else if (reg_req.addr == SIC_IN2_TOL_OFF) begin
            reg_rdata <= in2_tol;
         end else if (reg_req.addr == SIC_DIVN_LO_OFF) begin
            reg_rdata <= divn_lo;
         end else if (reg_req.addr == SIC_DIVN_HI_OFF) begin
            reg_rdata <= divn_hi;
         end else if (reg_req.addr == SIC_SYNTH_STD_OFF) begin
            reg_rdata <= synth_std;
         end else if (reg_req.addr == SIC_STATUS_OFF) begin
            reg_rdata <= {4'h0, div_active, loss_of_signal_pin,
                          sel_in2, (phase == SIC_RUN)};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

endmodule : sic_input_select

// [verif/sic_input_select_asserts.sv]
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the input selector
// ****************************************************************
module sic_input_select_asserts
   import sic_pkg::*;
#(
   parameter int INIT_CYCLES = 20
) (
   // Clock and reset
   input wire logic         clk,
   input wire logic         rstn,
   // Inputs watched
   input wire logic         source_select_pin,
   input wire sic_reg_req_t reg_req,
   // Outputs watched
   input wire logic         phase_cmp_pulse,
   input wire logic         dpll_holdover,
   input wire logic         selected_is_input2,
   input wire logic         loss_of_signal_pin,
   input wire logic         network_standard_bit,
   input wire logic         init_done
);
   int unsigned since_rel;

   // Cycles since reset release, saturating so it never wraps
   always_ff @(posedge clk or negedge rstn)
      if (!rstn) since_rel <= 0;
      else if (since_rel < INIT_CYCLES + 8) since_rel <= since_rel + 1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_init_time;
      init_done == (since_rel >= INIT_CYCLES + 2);
   endproperty
   a_init_time: assert property (p_init_time)
      else $error("init window length wrong");
   property p_sel_one;
      init_done && source_select_pin |=> !selected_is_input2;
   endproperty
   a_sel_one: assert property (p_sel_one)
      else $error("pin high did not pick input 1");
   property p_sel_two;
      init_done && !source_select_pin |=> selected_is_input2;
   endproperty
   a_sel_two: assert property (p_sel_two)
      else $error("pin low did not pick input 2");
   property p_hold_los;
      dpll_holdover == loss_of_signal_pin;
   endproperty
   a_hold_los: assert property (p_hold_los)
      else $error("holdover and alarm differ");
   property p_pulse_one;
      phase_cmp_pulse |=> !phase_cmp_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one)
      else $error("comparator pulse too long");
   property p_los_clear;
      phase_cmp_pulse |=> !loss_of_signal_pin;
   endproperty
   a_los_clear: assert property (p_los_clear)
      else $error("alarm kept after an edge");
   property p_std_write;
      init_done && reg_req.wr && reg_req.addr == SIC_MODE_CFG_OFF |-> ##2
         network_standard_bit == $past(reg_req.wdata[SIC_NET_STD_BIT], 2);
   endproperty
   a_std_write: assert property (p_std_write)
      else $error("standard bit not written");
   property p_std_keep;
      init_done && !$past(reg_req.wr) && !$past(reg_req.wr, 2) |->
         $stable(network_standard_bit);
   endproperty
   a_std_keep: assert property (p_std_keep)
      else $error("standard bit moved unasked");
endmodule : sic_input_select_asserts

bind sic_input_select sic_input_select_asserts #(.INIT_CYCLES(INIT_CYCLES))
   u_sic_input_select_asserts (.clk, .rstn, .source_select_pin, .reg_req,
   .phase_cmp_pulse, .dpll_holdover, .selected_is_input2, .loss_of_signal_pin,
   .network_standard_bit, .init_done);

// [verif/sic_ref_src.sv]
`timescale 1ns/1ps
// ****************************************************************
// Clock card supplying one reference
// ****************************************************************
module sic_ref_src (
   // Clock
   input  wire logic        clk,
   // Control
   input  wire logic        run,
   input  wire logic [15:0] half,
   // Reference out
   output logic             ref_out = 1'b0
);
   logic [15:0] cnt = 16'h0000;

   // Toggle each half period; a failed card parks low, as a dead line would
   always @(posedge clk)
      if (!run) begin
         ref_out <= 1'b0;
         cnt     <= 16'h0000;
      end else if (cnt == 16'h0000) begin
         ref_out <= ~ref_out;
         cnt     <= half - 16'h0001;
      end else cnt <= cnt - 16'h0001;
endmodule : sic_ref_src

// [verif/sic_input_select_bench.sv]
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench
// ****************************************************************
module sic_input_select_bench;
   import sic_pkg::*;
   localparam int INIT = 20;  // Short init window keeps the run brief
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   sic_strap_t   strap = '0;
   logic         src_sel = 1'b1;
   sic_reg_req_t req = '0;
   logic         run1 = 1'b0;
   logic         run2 = 1'b0;
   logic [15:0]  half = 16'h0003;
   logic         ref1, ref2, pulse, hold, sel2, los, std, done;
   logic [7:0]   rdata, v;
   int           error_cnt = 0;
   int           comparisons = 0;

   always #4 clk = ~clk;

   sic_input_select #(.INIT_CYCLES(INIT)) u_sic_input_select (.clk(clk), .rstn(rstn),
      .expected_freq_strap(strap), .reference_input_1(ref1), .reference_input_2(ref2),
      .source_select_pin(src_sel), .reg_req(req), .reg_rdata(rdata),
      .phase_cmp_pulse(pulse), .dpll_holdover(hold), .selected_is_input2(sel2),
      .loss_of_signal_pin(los), .network_standard_bit(std), .init_done(done));
   sic_ref_src u_sic_ref_src_1 (.clk(clk), .run(run1), .half(half), .ref_out(ref1));
   sic_ref_src u_sic_ref_src_2 (.clk(clk), .run(run2), .half(half), .ref_out(ref2));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) #1 req.wr = 1'b0;
   endtask : wr
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk) #1 req.rd = 1'b0;
      v = rdata;
      chk(what, 16'(exp), 16'(v));
   endtask : rchk
   // Expected code for a strap word, in the package's code order
   function automatic logic [3:0] fcode(input sic_strap_t s);
      if (s.freq_sel == 3'd0) return SIC_F_8K;
      if (s.freq_sel == 3'd1) return s.net_std ? SIC_F_1544K : SIC_F_2048K;
      return 4'(s.freq_sel) + 4'h1;
   endfunction : fcode
   task automatic boot(input sic_strap_t s);
      @(posedge clk) #1 rstn = 1'b0;
      strap = s;
      src_sel = 1'b1;
      repeat (10) @(posedge clk);
      #1 rstn = 1'b1;
      for (int i = 0; i < INIT + 8 && done !== 1'b1; i++) @(negedge clk);
      chk("init_done", 16'h1, 16'(done));
   endtask : boot
   // Cycles between comparator pulses; the first two settle the divider
   task automatic gap(input string what, input logic [15:0] exp);
      int n;
      repeat (3) begin
         @(negedge clk);
         for (n = 1; n < 50000 && pulse !== 1'b1; n++) @(negedge clk);
      end
      chk(what, exp, 16'(n));
   endtask : gap

   task automatic t_straps;
      sic_strap_t s;
      for (int i = 0; i < 16; i++) begin
         s = 4'(i);
         boot(s);
         rchk("freq1", SIC_IN1_FREQ_OFF, {4'h0, fcode(s)});
         rchk("freq2", SIC_IN2_FREQ_OFF, {4'h0, fcode(s)});
         chk("std_pin", 16'(s.net_std), 16'(std));
         rchk("mode", SIC_MODE_CFG_OFF, {5'h00, s.net_std, 2'h0});
         rchk("out_std", SIC_OUT_STD_OFF, {1'b0, {2{s.net_std}}, 5'h00});
         rchk("syn_std", SIC_SYNTH_STD_OFF, {3'h0, s.net_std, 4'h0});
         rchk("tol2", SIC_IN2_TOL_OFF, SIC_TOL_RST);
      end
   endtask : t_straps
   task automatic t_regs;
      strap = 4'h0;  // Late strap change must not reach the registers
      repeat (4) @(posedge clk);
      rchk("late_strap", SIC_IN1_FREQ_OFF, {4'h0, SIC_F_77760K});
      chk("late_std", 16'h1, 16'(std));
      wr(SIC_IN1_TOL_OFF, 8'h1e);
      rchk("tol1", SIC_IN1_TOL_OFF, 8'h1e);
      wr(SIC_DIVN_HI_OFF, 8'hff);
      rchk("divn_hi", SIC_DIVN_HI_OFF, 8'h3f);
      rchk("unmapped", 8'h10, 8'h00);
      wr(SIC_MODE_CFG_OFF, 8'h00);
      repeat (3) @(negedge clk);
      chk("std_sdh", 16'h0, 16'(std));
   endtask : t_regs
   task automatic t_lock;
      @(posedge clk) #1 run1 = 1'b1;
      wr(SIC_IN1_FREQ_OFF, {4'h0, SIC_F_19440K});
      gap("direct", 16'd6);
      wr(SIC_DIVN_LO_OFF, 8'h03);
      wr(SIC_DIVN_HI_OFF, 8'h00);
      wr(SIC_IN1_FREQ_OFF, 8'h80);
      gap("divn", 16'd24);
      chk("rise_lvl", 16'h1, 16'(ref1));
      wr(SIC_TEST_CTRL_OFF, 8'h04);
      gap("fall", 16'd24);
      chk("fall_lvl", 16'h0, 16'(ref1));
      half = 16'h0001;
      wr(SIC_IN1_FREQ_OFF, {4'h4, SIC_F_77760K});
      gap("to_8k", 16'(9720 * 2));
   endtask : t_lock
   task automatic t_select;
      wr(SIC_IN2_FREQ_OFF, {4'h0, SIC_F_19440K});
      @(posedge clk) #1 half = 16'h0003;
      run1 = 1'b0;
      run2 = 1'b1;
      src_sel = 1'b0;
      gap("input2", 16'd6);
      chk("sel2", 16'h1, 16'(sel2));
      chk("los_idle", 16'h0, 16'(los));
      @(posedge clk) #1 run2 = 1'b0;
      repeat (24) @(negedge clk);
      chk("los", 16'h1, 16'(los));
      chk("holdover", 16'h1, 16'(hold));
   endtask : t_select

   task automatic results;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results

   // Watchdog well beyond the expected run of about 60k cycles
   initial begin
      #2000000;
      error_cnt++;
      results;
   end
   // Main sequence
   initial begin
      t_straps;
      t_regs;
      t_lock;
      t_select;
      results;
   end
endmodule : sic_input_select_bench
